// ### logic/lpc_defs.svh
/*
 * Register offsets, field positions and reset values of the printer
 * data transfer port.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_STATE       8'h04
`define OFS_IRQ_STATUS  8'h08
`define OFS_IRQ_MASK    8'h0c
`define OFS_LAST_CHAR   8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_ENABLE     0
`define CTRL_NEW_LINE   1
`define ST_DATA_READY   0
`define ST_EOP          1
`define ST_ERROR        2
`define ST_FIRST        3
`define ST_POS_LO       8
`define IRQ_ACCEPT      0
`define IRQ_REJECT      1
`define IRQ_EOP         2
`define IRQ_ERROR       3
`define IRQ_BITS        4

// ---------------------------------------------------------------
// Host channel field positions
// ---------------------------------------------------------------
`define Q_FUNC_SEL      0
`define Q_EQUIP_LO      7
`define Q_EQUIP_HI      10

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_CTRL_ENABLE 1'b1
`define RST_DATA_READY  1'b1
`define RST_IRQ_MASK    4'h0

`endif

// ### logic/lpc_pkg.sv
/*
 * Types shared by the printer data transfer port.
 * Assumes nothing of its surroundings.
 */
package lpc_pkg;
   // Host answer sequencer
   typedef enum logic [0:0]
   {
      ANS_IDLE = 1'b0,
      ANS_HOLD = 1'b1
   } ans_state_t;
   typedef logic [15:0] word16_t;
   typedef logic [7:0]  char_t;
endpackage

// ### logic/printer_port.sv
/*
 * Host data transfer path of a line printer controller with an
 * AHB-Lite register slave and one level interrupt.
 * Assumes host channel and printer pins are asynchronous to clk, the
 * host holds Q and A steady before raising its write strobe, and one
 * printer is attached.
 */
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
// Functional notes
// RQ1 - Function select low with an output write strobe is a transfer.
// RQ2 - The host puts the character in A bits 0..7, upper bits zero.
// RQ3 - The first character of each line is a control, not printed.
// RQ4 - Reject when not ready, busy, data not ready or protect fault.
// RQ5 - A transfer clears the end-of-operation and error flags.
// RQ6 - One instance serves exactly one printer.
// RQ7 - Data ready is true only while the printer can take a char.
// RQ8 - Answer only when Q bits 7..10 match the equipment jumpers.
// RQ9 - The host drives Q bits 11..15 to zero.
// RQ10 - For six-bit characters the host zeroes A bits 6 and 7.
// RQ11 - A reject changes nothing and answers reject, not reply; the code still sets the reject bit of the interrupt status.
`timescale 1ns/1ps
`include "lpc_defs.svh"
module printer_port (
   input  wire logic            clk,
   input  wire logic            rstn,
   input  wire logic            hsel,
   input  wire logic [7:0]      haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic      [31:0]     hrdata,
   output logic                 hreadyout,
   output logic                 hresp,
   input  wire lpc_pkg::word16_t q_bus,
   input  wire lpc_pkg::word16_t a_bus,
   input  wire logic            write_strobe,
   input  wire logic [3:0]      equip_jumper,
   input  wire logic            protect_fault,
   input  wire logic            printer_ready,
   input  wire logic            printer_busy,
   input  wire logic            printer_ack,
   input  wire logic            line_done,
   input  wire logic            parity_error,
   output logic                 reply,
   output logic                 reject,
   output lpc_pkg::char_t       print_data,
   output logic                 print_strobe,
   output logic                 print_is_ctrl,
   output logic                 irq
);
   import lpc_pkg::*;

   localparam int SW = 43;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [SW-1:0] raw_in;
   logic [SW-1:0] syn;
   word16_t       q_s;
   word16_t       a_s;
   logic [3:0]    jmp_s;
   logic          wr_s, prot_s, rdy_s, busy_s, ack_s, done_s, perr_s;

   assign raw_in = {q_bus, a_bus, equip_jumper, write_strobe,
                    protect_fault, printer_ready, printer_busy,
                    printer_ack, line_done, parity_error};
   assign {q_s, a_s, jmp_s, wr_s, prot_s, rdy_s, busy_s,
           ack_s, done_s, perr_s} = syn;

   sync2 #(.W(SW)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (raw_in),
      .q    (syn)
   );

   // ------------------------------------------------------------
   // Edge detection and decode
   // ------------------------------------------------------------
   logic wr_p_q, ack_p_q, done_p_q, perr_p_q;
   logic enable_q, first_q, data_ready_q, eop_q, error_q;
   logic [7:0] line_pos_q;
   logic new_line_wr;
   logic wr_rise, xfer_hit, accept, refuse;

   // Previous samples of synchronised levels
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         {wr_p_q, ack_p_q, done_p_q, perr_p_q} <= 4'h0;
      else
         {wr_p_q, ack_p_q, done_p_q, perr_p_q} <=
            {wr_s, ack_s, done_s, perr_s};
   end

   // Transfer decode and reject conditions
   assign wr_rise  = wr_s & ~wr_p_q;
   assign xfer_hit = wr_rise & enable_q
                   & ~q_s[`Q_FUNC_SEL]                 // see RQ1
                   & (q_s[`Q_EQUIP_HI:`Q_EQUIP_LO] == jmp_s); // see RQ8
   assign accept   = xfer_hit & rdy_s & ~busy_s & data_ready_q
                   & ~prot_s;                           // see RQ4
   assign refuse   = xfer_hit & ~accept;                // see RQ11

   // ------------------------------------------------------------
   // Host answer
   // ------------------------------------------------------------
   ans_state_t ans_q;

   // Reply or reject held until the host drops its strobe
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ans_q  <= ANS_IDLE;
         reply  <= 1'b0;
         reject <= 1'b0;
      end
      else
      begin
         case (ans_q)
            ANS_IDLE:
               if (xfer_hit)
               begin
                  ans_q  <= ANS_HOLD;
                  reply  <= accept;
                  reject <= refuse;  // see RQ11
               end
            ANS_HOLD:
               if (!wr_s)
               begin
                  ans_q  <= ANS_IDLE;
                  reply  <= 1'b0;
                  reject <= 1'b0;
               end
            default:
               ans_q <= ANS_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Printer data path
   // ------------------------------------------------------------
   // One-cycle strobe to the single attached printer
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         print_data    <= 8'h00;
         print_strobe  <= 1'b0;
         print_is_ctrl <= 1'b0;
      end
      else
      begin
         print_strobe <= accept;                        // see RQ6
         if (accept)
         begin
            print_data    <= a_s[7:0];
            print_is_ctrl <= first_q;                   // see RQ3
         end
      end
   end

   // Line position; the first char of a line is the control char
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         first_q    <= 1'b1;
         line_pos_q <= 8'h00;
      end
      else if (new_line_wr || (done_s && !done_p_q))
      begin
         first_q    <= 1'b1;
         line_pos_q <= 8'h00;
      end
      else if (accept)
      begin
         first_q    <= 1'b0;                            // see RQ3
         line_pos_q <= line_pos_q + 8'h01;
      end
   end

   // Data ready drops on a transfer, rises on printer acknowledge
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         data_ready_q <= `RST_DATA_READY;
      else if (ack_s && !ack_p_q)
         data_ready_q <= 1'b1;                          // see RQ7
      else if (accept)
         data_ready_q <= 1'b0;                          // see RQ7
   end

   // End-of-operation and error; a new event beats the clear
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         eop_q   <= 1'b0;
         error_q <= 1'b0;
      end
      else
      begin
         eop_q   <= (done_s & ~done_p_q) | (eop_q & ~accept); // see RQ5
         error_q <= (perr_s & ~perr_p_q) | (error_q & ~accept);
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite slave and registers
   // ------------------------------------------------------------
   logic       wr_ph_q;
   logic [7:0] addr_q;
   logic       ap_rd;
   logic [`IRQ_BITS-1:0] irq_st_q, irq_mask_q, irq_set, irq_clr;
   char_t      last_q;

   assign ap_rd = hsel & hready & htrans[1] & ~hwrite;
   assign new_line_wr = wr_ph_q && addr_q == `OFS_CTRL
                        && hwdata[`CTRL_NEW_LINE];

   // Address phase capture; zero wait states, always OKAY
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_ph_q   <= 1'b0;
         addr_q    <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         wr_ph_q <= hsel & hready & htrans[1] & hwrite;
         if (hsel && hready && htrans[1])
            addr_q <= {haddr[7:2], 2'b00};
      end
   end

   // Writable registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         enable_q   <= `RST_CTRL_ENABLE;
         irq_mask_q <= `RST_IRQ_MASK;
      end
      else if (wr_ph_q)
      begin
         if (addr_q == `OFS_CTRL)
            enable_q <= hwdata[`CTRL_ENABLE];
         if (addr_q == `OFS_IRQ_MASK)
            irq_mask_q <= hwdata[`IRQ_BITS-1:0];
      end
   end

   // Read data registered at the end of the address phase
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         hrdata <= 32'h0000_0000;
      else if (ap_rd)
      begin
         case ({haddr[7:2], 2'b00})
            `OFS_CTRL:       hrdata <= {31'h0, enable_q};
            `OFS_STATE:      hrdata <= {16'h0, line_pos_q, 4'h0,
                                        first_q, error_q, eop_q,
                                        data_ready_q};
            `OFS_IRQ_STATUS: hrdata <= {28'h0, irq_st_q};
            `OFS_IRQ_MASK:   hrdata <= {28'h0, irq_mask_q};
            `OFS_LAST_CHAR:  hrdata <= {24'h0, last_q};
            default:         hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Last accepted character
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         last_q <= 8'h00;
      else if (accept)
         last_q <= a_s[7:0];
   end

   // Sticky events, cleared by read; a new event wins over the clear
   assign irq_set = {perr_s & ~perr_p_q, done_s & ~done_p_q,
                     refuse, accept};
   assign irq_clr = (ap_rd && {haddr[7:2], 2'b00} == `OFS_IRQ_STATUS)
                    ? {`IRQ_BITS{1'b1}} : {`IRQ_BITS{1'b0}};

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_st_q <= 4'h0;
         irq      <= 1'b0;
      end
      else
      begin
         irq_st_q <= irq_set | (irq_st_q & ~irq_clr);
         irq      <= |(irq_st_q & irq_mask_q);
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_func_sel;
      @(posedge clk) disable iff (!rstn)
      (wr_rise && q_s[`Q_FUNC_SEL]) |-> !xfer_hit;
   endproperty
   a_func_sel: assert property (p_func_sel) // see RQ1
      else $error("function select high taken as transfer");

   property p_equip;
      @(posedge clk) disable iff (!rstn)
      $rose(reply | reject) |->
         $past(q_s[`Q_EQUIP_HI:`Q_EQUIP_LO]) == $past(jmp_s);
   endproperty
   a_equip: assert property (p_equip) // see RQ8
      else $error("answer given to a foreign equipment code");

   property p_ctrl_first;
      @(posedge clk) disable iff (!rstn)
      (accept && first_q && !new_line_wr && !(done_s && !done_p_q))
         |=> print_strobe && print_is_ctrl ##1 !first_q;
   endproperty
   a_ctrl_first: assert property (p_ctrl_first) // see RQ3
      else $error("first character of line not marked control");

   property p_reject;
      @(posedge clk) disable iff (!rstn)
      (xfer_hit && (!rdy_s || busy_s || !data_ready_q || prot_s))
         |=> reject && !reply && !print_strobe;
   endproperty
   a_reject: assert property (p_reject) // see RQ4
      else $error("transfer taken despite a reject condition");

   property p_clear_flags;
      @(posedge clk) disable iff (!rstn)
      (accept && !(done_s && !done_p_q) && !(perr_s && !perr_p_q))
         |=> !eop_q && !error_q;
   endproperty
   a_clear_flags: assert property (p_clear_flags) // see RQ5
      else $error("transfer left end or error flag set");

   property p_one_strobe;
      @(posedge clk) disable iff (!rstn)
      print_strobe |=> !print_strobe;
   endproperty
   a_one_strobe: assert property (p_one_strobe) // see RQ6
      else $error("printer strobe longer than one cycle");

   property p_ready_drop;
      @(posedge clk) disable iff (!rstn)
      (accept && !(ack_s && !ack_p_q)) |=> !data_ready_q;
   endproperty
   a_ready_drop: assert property (p_ready_drop) // see RQ7
      else $error("data ready stayed true after a transfer");

   property p_reject_still;
      @(posedge clk) disable iff (!rstn)
      (refuse && !new_line_wr && !(done_s && !done_p_q)
       && !(perr_s && !perr_p_q))
         |=> $stable(line_pos_q) && $stable(last_q) && $stable(eop_q)
             && $stable(error_q) && !print_strobe;
   endproperty
   a_reject_still: assert property (p_reject_still) // see RQ11
      else $error("rejected transfer changed block state");
endmodule

// ### logic/sync2.sv
/*
 * Two flip-flop synchroniser for a group of level inputs.
 * Assumes inputs are stable for several clocks around each change.
 */
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // Only the second stage reads the first
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ### tb/host_channel.sv
/*
 * Host channel model: drives Q, A and the output strobe.
 * Assumes clk is the block clock; answers are levels.
 */
`timescale 1ns/1ps
module host_channel (
   input  wire logic        clk,
   input  wire logic        reply,
   input  wire logic        reject,
   output lpc_pkg::word16_t q_bus,
   output lpc_pkg::word16_t a_bus,
   output logic             write_strobe
);
   import lpc_pkg::*;
   // Idle lines at time zero
   initial
   begin
      q_bus = 16'h0000;
      a_bus = 16'h0000;
      write_strobe = 1'b0;
   end
   // ------------
   // Transfer
   // ------------
   // Result 0 none, 1 reply, 2 reject
   task automatic xfer(input logic fs, input logic [3:0] eq,
                       input char_t ch, output logic [1:0] res);
      int n;
      res = 2'd0;
      q_bus <= {5'h00, eq, 6'h00, fs};
      a_bus <= {8'h00, ch};
      repeat (3) @(posedge clk);
      write_strobe <= 1'b1;
      for (n = 0; n < 12 && res == 2'd0; n++)
      begin
         @(posedge clk);
         res = reply ? 2'd1 : (reject ? 2'd2 : 2'd0);
      end
      write_strobe <= 1'b0;
      for (n = 0; n < 12 && (reply || reject); n++)
         @(posedge clk);
      // Released lines must not hold the old value
      q_bus <= ~q_bus;
      a_bus <= ~a_bus;
      @(posedge clk);
   endtask
endmodule

// ### tb/printer_port_bench.sv
/*
 * Self-checking bench of the printer data transfer port.
 * Assumes host_channel and lpc_defs.svh are on the compile path.
 */
`timescale 1ns/1ps
`include "lpc_defs.svh"
module printer_port_bench;
   import lpc_pkg::*;
   localparam logic [3:0] EQ = 4'h5;
   logic [3:0]  jumper = EQ;
   logic        six_bit = 1'b0;
   logic        clk = 1'b0;
   logic        rstn, hsel, hwrite, hresp, hreadyout;
   logic [7:0]  haddr, last_ch;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, r;
   wire         hready = hreadyout;
   word16_t     q_bus, a_bus;
   logic        write_strobe, protect_fault, printer_ready;
   logic        printer_busy, printer_ack, line_done, parity_error;
   logic        reply, reject, print_strobe, print_is_ctrl, irq;
   char_t       print_data;
   logic [8:0]  expq[$];
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          seed = 11;
   int          i;

   always #20 clk = ~clk;

   printer_port dut (.clk(clk), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .q_bus(q_bus),
      .a_bus(a_bus), .write_strobe(write_strobe), .equip_jumper(jumper),
      .protect_fault(protect_fault), .printer_ready(printer_ready),
      .printer_busy(printer_busy), .printer_ack(printer_ack),
      .line_done(line_done), .parity_error(parity_error),
      .reply(reply), .reject(reject), .print_data(print_data),
      .print_strobe(print_strobe), .print_is_ctrl(print_is_ctrl),
      .irq(irq));

   host_channel host (.clk(clk), .reply(reply), .reject(reject),
      .q_bus(q_bus), .a_bus(a_bus), .write_strobe(write_strobe));

   // ------------
   // Helpers
   // ------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // One AHB-Lite single transfer
   task automatic bus(input logic wr, input logic [7:0] ad,
                      input logic [31:0] wd, output logic [31:0] rd);
      haddr <= ad;
      hwrite <= wr;
      htrans <= 2'b10;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] ad,
                         input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, ad, 32'h0, v);
      check(what, v & m, exp);
   endtask

   // Host transfer with expected answer and printed unit
   task automatic send(input logic fs, input logic [3:0] eq,
                       input logic [1:0] exp, input logic ctl);
      logic [1:0] res;
      last_ch = 8'($random(seed));
      if (six_bit)
         last_ch[7:6] = 2'b00;
      if (exp == 2'd1)
         expq.push_back({ctl, last_ch});
      host.xfer(fs, eq, last_ch, res);
      check("answer", {30'h0, res}, {30'h0, exp});
   endtask

   // Event pins pulsed by mask {line_done, parity_error, printer_ack}
   task automatic pulse(input logic [2:0] m);
      {line_done, parity_error, printer_ack} <= m;
      repeat (4) @(posedge clk);
      {line_done, parity_error, printer_ack} <= 3'b000;
      repeat (5) @(posedge clk);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Printed units compared in order
   always @(posedge clk)
      if (print_strobe === 1'b1)
         check("print", {23'h0, print_is_ctrl, print_data}, (expq.size()
            != 0) ? {23'h0, expq.pop_front()} : 32'hffffffff);

   initial
   begin
      #400000;
      n_mismatch++;
      finish_test();
   end

   // ------------
   // Scenarios
   // ------------
   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      {protect_fault, printer_busy, printer_ack} = 3'b000;
      {line_done, parity_error} = 2'b00;
      printer_ready = 1'b1;
      rstn = 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      hsel <= 1'b1;
      @(posedge clk);
      rd_chk("ctrl", `OFS_CTRL, 32'hffffffff, 32'h1);
      rd_chk("state", `OFS_STATE, 32'hf, 32'h9);
      rd_chk("mask", `OFS_IRQ_MASK, 32'hffffffff, 32'h0);
      rd_chk("unmapped", 8'h14, 32'hffffffff, 32'h0);
      bus(1'b1, `OFS_IRQ_MASK, 32'hf, r);
      send(1'b0, EQ, 2'd1, 1'b1);
      rd_chk("state", `OFS_STATE, 32'hf, 32'h0);
      check("irq", {31'h0, irq}, 32'h1);
      rd_chk("status", `OFS_IRQ_STATUS, 32'hf, 32'h1);
      rd_chk("status", `OFS_IRQ_STATUS, 32'hf, 32'h0);
      send(1'b0, EQ, 2'd2, 1'b0);
      pulse(3'b001);
      // Not ready, busy, protect fault in turn
      for (i = 0; i < 3; i++)
      begin
         printer_ready <= (i != 0);
         printer_busy <= (i == 1);
         protect_fault <= (i == 2);
         send(1'b0, EQ, 2'd2, 1'b0);
      end
      protect_fault <= 1'b0;
      printer_ready <= 1'b1;
      six_bit = 1'b1;
      send(1'b0, EQ, 2'd1, 1'b0);
      rd_chk("pos", `OFS_STATE, 32'hff00, 32'h200);
      rd_chk("last", `OFS_LAST_CHAR, 32'hff, {24'h0, last_ch});
      rd_chk("status", `OFS_IRQ_STATUS, 32'hf, 32'h3);
      send(1'b1, EQ, 2'd0, 1'b0);
      send(1'b0, EQ ^ 4'h1, 2'd0, 1'b0);
      // Disabled port gives no answer; new line marks next char control
      bus(1'b1, `OFS_CTRL, 32'h0, r);
      send(1'b0, EQ, 2'd0, 1'b0);
      bus(1'b1, `OFS_CTRL, 32'h3, r);
      pulse(3'b001);
      send(1'b0, EQ, 2'd1, 1'b1);
      pulse(3'b100);
      pulse(3'b010);
      pulse(3'b001);
      rd_chk("state", `OFS_STATE, 32'hf, 32'hf);
      protect_fault <= 1'b1;
      send(1'b0, EQ, 2'd2, 1'b0);
      protect_fault <= 1'b0;
      rd_chk("state", `OFS_STATE, 32'hf, 32'hf);
      send(1'b0, EQ, 2'd1, 1'b1);
      rd_chk("state", `OFS_STATE, 32'h6, 32'h0);
      bus(1'b1, `OFS_IRQ_MASK, 32'h0, r);
      bus(1'b0, `OFS_IRQ_STATUS, 32'h0, r);
      jumper <= 4'ha;
      send(1'b0, 4'ha, 2'd2, 1'b0);
      repeat (3) @(posedge clk);
      check("irq", {31'h0, irq}, 32'h0);
      check("queue", expq.size(), 32'h0);
      finish_test();
   end
endmodule
